// file: rtl/pdph_defs.svh
// Constants of the data phase handshake link
`ifndef PDPH_DEFS_SVH
`define PDPH_DEFS_SVH
`define PDPH_DATA_W 32
`define PDPH_ADDR_W 32
`define PDPH_BUF_DEPTH 2
`define PDPH_LEN_W 8
`endif

// file: rtl/pdph_pkg.sv
// Types of the data phase handshake link
`include "pdph_defs.svh"
package pdph_pkg;
  typedef enum logic [2:0] {
    PDPH_M_IDLE = 3'b001,
    PDPH_M_ADDR = 3'b010,
    PDPH_M_DATA = 3'b100
  } pdph_mstate_t;
  typedef enum logic [2:0] {
    PDPH_T_IDLE = 3'b001,
    PDPH_T_DATA = 3'b010,
    PDPH_T_DONE = 3'b100
  } pdph_tstate_t;
endpackage

// file: rtl/pdph_if.sv
// Shared bus between the master end and the target end
`timescale 1ns/1ps
`default_nettype none
`include "pdph_defs.svh"
interface pdph_if;
  logic frame_n;
  logic irdy_n;
  logic trdy_n;
  logic write;
  logic [`PDPH_DATA_W-1:0] m_ad;
  logic m_ad_oe;
  logic [`PDPH_DATA_W-1:0] t_ad;
  logic t_ad_oe;
  logic [`PDPH_DATA_W-1:0] ad;
  assign ad = m_ad_oe ? m_ad : (t_ad_oe ? t_ad : '0);
  modport master (output frame_n, output irdy_n, output write, output m_ad, output m_ad_oe,
                  input trdy_n, input ad);
  modport target (input frame_n, input irdy_n, input write, input ad,
                  output trdy_n, output t_ad, output t_ad_oe);
endinterface
`default_nettype wire

// file: rtl/pdph_master.sv
// Bus master end: runs one burst with wait cycles and a two-entry write buffer
`timescale 1ns/1ps
`default_nettype none
`include "pdph_defs.svh"
module pdph_master
  import pdph_pkg::*;
#(
  parameter int DATA_W = `PDPH_DATA_W,
  parameter int LEN_W = `PDPH_LEN_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic start_write,
  input wire logic [DATA_W-1:0] start_addr,
  input wire logic [LEN_W-1:0] start_len,
  output logic busy,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [DATA_W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data,
  pdph_if.master bus
);
  pdph_mstate_t state_q;
  logic [LEN_W-1:0] left_q;
  logic write_q;
  logic [DATA_W-1:0] buf_q [2];
  logic [1:0] cnt_q;
  logic rp_q;
  logic wp_q;
  logic rd_full_q;
  logic [DATA_W-1:0] rd_q;
  logic have_word;
  logic can_take;
  logic done;
  logic last;
  logic push;
  logic pop;
  logic final_phase;
  logic frame_n_d;
  logic irdy_n_d;
  logic write_d;
  logic [DATA_W-1:0] m_ad_d;
  logic m_ad_oe_d;

  assign have_word = write_q ? (cnt_q != 2'h0) : 1'b1;
  assign can_take = write_q ? 1'b1 : !rd_full_q;
  assign done = state_q == PDPH_M_DATA && !bus.irdy_n && !bus.trdy_n;
  assign last = left_q == {{(LEN_W-1){1'b0}}, 1'b1};
  assign busy = state_q != PDPH_M_IDLE;
  // Write words queue at any time, even between bursts
  // They leave in the order they were taken
  assign wr_ready = cnt_q != 2'h2;
  assign push = wr_valid && wr_ready;
  assign pop = done && write_q;
  assign rd_valid = rd_full_q;
  assign rd_data = rd_q;

  // Burst sequencing and data phase count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= PDPH_M_IDLE;
      left_q <= '0;
      write_q <= 1'b0;
    end else begin
      case (state_q)
        PDPH_M_IDLE: begin
          if (start && start_len != '0) begin
            state_q <= PDPH_M_ADDR;
            left_q <= start_len;
            write_q <= start_write;
          end
        end
        PDPH_M_ADDR: state_q <= PDPH_M_DATA;
        PDPH_M_DATA: begin
          if (done) begin
            left_q <= left_q - {{(LEN_W-1){1'b0}}, 1'b1};
            if (last) begin
              state_q <= PDPH_M_IDLE;
            end
          end
        end
        default: state_q <= PDPH_M_IDLE;
      endcase
    end
  end

  // Next values of the bus pins
  always_comb begin
    final_phase = last;
    frame_n_d = 1'b1;
    irdy_n_d = 1'b1;
    write_d = bus.write;
    m_ad_d = bus.m_ad;
    m_ad_oe_d = 1'b0;
    case (state_q)
      PDPH_M_IDLE: begin
        if (start && start_len != '0) begin
          frame_n_d = 1'b0;
          write_d = start_write;
          m_ad_d = start_addr;
          m_ad_oe_d = 1'b1;
        end
      end
      PDPH_M_ADDR, PDPH_M_DATA: begin
        if (!(done && last)) begin
          m_ad_oe_d = write_q;
          if (write_q) begin
            if (done) begin
              // Next word: second entry or the one arriving now
              irdy_n_d = !(cnt_q > 2'h1 || push);
              if (cnt_q == 2'h1) begin
                m_ad_d = wr_data;
              end else begin
                m_ad_d = buf_q[!rp_q];
              end
            end else begin
              irdy_n_d = !(have_word || push);
              if (have_word) begin
                m_ad_d = buf_q[rp_q];
              end else begin
                m_ad_d = wr_data;
              end
            end
          end else begin
            // A word taken now fills the holding register, so wait
            irdy_n_d = done || !(can_take || rd_ready);
          end
          // Frame rises only with irdy asserted in the final phase
          if (done) begin
            final_phase = left_q == LEN_W'(2);
          end
          frame_n_d = final_phase && !irdy_n_d;
        end
      end
      default: begin
        frame_n_d = 1'b1;
      end
    endcase
  end

  // Bus pins, registered from the next values
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus.frame_n <= 1'b1;
      bus.irdy_n <= 1'b1;
      bus.write <= 1'b0;
      bus.m_ad <= '0;
      bus.m_ad_oe <= 1'b0;
    end else begin
      bus.frame_n <= frame_n_d;
      bus.irdy_n <= irdy_n_d;
      bus.write <= write_d;
      bus.m_ad <= m_ad_d;
      bus.m_ad_oe <= m_ad_oe_d;
    end
  end

  // Two-entry write buffer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 2'h0;
      rp_q <= 1'b0;
      wp_q <= 1'b0;
    end else begin
      if (push) begin
        buf_q[wp_q] <= wr_data;
        wp_q <= !wp_q;
      end
      if (pop) begin
        rp_q <= !rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Read word holding register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_full_q <= 1'b0;
      rd_q <= '0;
    end else begin
      if (done && !write_q) begin
        rd_full_q <= 1'b1;
        rd_q <= bus.ad;
      end else if (rd_ready) begin
        rd_full_q <= 1'b0;
      end
    end
  end
endmodule // pdph_master
`default_nettype wire

// file: rtl/pdph_target.sv
// Target end: answers data phases with target ready and a two-entry buffer
`timescale 1ns/1ps
`default_nettype none
`include "pdph_defs.svh"
module pdph_target
  import pdph_pkg::*;
#(
  parameter int DATA_W = `PDPH_DATA_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic [DATA_W-1:0] addr,
  output logic addr_valid,
  output logic sink_valid,
  input wire logic sink_ready,
  output logic [DATA_W-1:0] sink_data,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [DATA_W-1:0] src_data,
  pdph_if.target bus
);
  pdph_tstate_t state_q;
  logic write_q;
  logic [DATA_W-1:0] buf_q [2];
  logic [1:0] cnt_q;
  logic rp_q;
  logic wp_q;
  logic done;
  logic push;
  logic pop;
  logic ok;
  logic wbuf_q;

  assign done = state_q == PDPH_T_DATA && !bus.irdy_n && !bus.trdy_n;
  // Write: room in buffer; read: a word ready to drive
  assign ok = write_q ? (cnt_q != 2'h2) : (cnt_q != 2'h0 && !wbuf_q);
  assign push = write_q ? done : (src_valid && src_ready);
  assign pop = (sink_valid && sink_ready) || (!write_q && done);
  // Read words fetched only for a pending phase, so none are left over
  assign src_ready = !write_q && cnt_q == 2'h0 && state_q == PDPH_T_DATA && !bus.irdy_n;
  // Write words drain to the sink even after the burst has ended
  assign sink_valid = wbuf_q && cnt_q != 2'h0;
  assign sink_data = buf_q[rp_q];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= PDPH_T_IDLE;
      write_q <= 1'b0;
      addr <= '0;
      addr_valid <= 1'b0;
    end else begin
      addr_valid <= 1'b0;
      case (state_q)
        PDPH_T_IDLE: begin
          if (!bus.frame_n) begin
            state_q <= PDPH_T_DATA;
            write_q <= bus.write;
            addr <= bus.ad;
            addr_valid <= 1'b1;
          end
        end
        PDPH_T_DATA: begin
          if (done && bus.frame_n) begin
            state_q <= PDPH_T_DONE;
          end
        end
        PDPH_T_DONE: begin
          if (bus.frame_n && bus.irdy_n) begin
            state_q <= PDPH_T_IDLE;
          end
        end
        default: state_q <= PDPH_T_IDLE;
      endcase
    end
  end

  // Target ready and read data pins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus.trdy_n <= 1'b1;
      bus.t_ad <= '0;
      bus.t_ad_oe <= 1'b0;
    end else begin
      bus.trdy_n <= 1'b1;
      bus.t_ad_oe <= 1'b0;
      if (state_q == PDPH_T_DATA && !(done && bus.frame_n)) begin
        bus.t_ad_oe <= !write_q;
        if (write_q) begin
          bus.trdy_n <= !(done ? (cnt_q == 2'h0 || pop) : (ok || pop));
        end else if (done) begin
          bus.trdy_n <= !(cnt_q == 2'h2 || push);
          bus.t_ad <= (cnt_q == 2'h2) ? buf_q[!rp_q] : src_data;
        end else begin
          bus.trdy_n <= !(ok || push);
          bus.t_ad <= ok ? buf_q[rp_q] : src_data;
        end
      end
    end
  end

  // Two-entry data buffer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 2'h0;
      rp_q <= 1'b0;
      wp_q <= 1'b0;
      wbuf_q <= 1'b0;
    end else begin
      if (push) begin
        buf_q[wp_q] <= write_q ? bus.ad : src_data;
        wp_q <= !wp_q;
        wbuf_q <= write_q;
      end
      if (pop) begin
        rp_q <= !rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // pdph_target
`default_nettype wire

// file: tb/pdph_checker.sv
// Bus protocol assertions for the handshake link
`timescale 1ns/1ps
`default_nettype none
module pdph_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic write,
  input wire logic [31:0] m_ad,
  input wire logic m_ad_oe,
  input wire logic t_ad_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_done;
    !irdy_n && !trdy_n;
  endsequence
  sequence s_wr_wait;
    !irdy_n && trdy_n && write;
  endsequence
  a_addr_phase: assert property ($fell(frame_n) |-> m_ad_oe && irdy_n)
    else $error("address phase wrong");
  a_frame_last: assert property ($rose(frame_n) |-> !irdy_n)
    else $error("frame dropped without irdy");
  a_irdy_holds: assert property (!irdy_n && trdy_n |=> !irdy_n)
    else $error("irdy released early");
  a_trdy_holds: assert property (!trdy_n && irdy_n && !frame_n |=> !trdy_n)
    else $error("trdy released early");
  a_write_drive: assert property (!irdy_n && write |-> m_ad_oe && !t_ad_oe)
    else $error("write data not driven");
  a_read_drive: assert property (!trdy_n && !write |-> t_ad_oe && !m_ad_oe)
    else $error("read data not driven");
  a_wait_stable: assert property (s_wr_wait |=> $stable(m_ad))
    else $error("write data moved in wait");
  a_bus_idle: assert property (frame_n ##0 s_done |=> irdy_n && !m_ad_oe)
    else $error("bus not idle after last phase");
endmodule // pdph_checker
`default_nettype wire

// file: tb/tb.sv
// Testbench joining the master end and the target end
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pdph_pkg::*;
  logic ref_clk = 0, rst = 1, start = 0, start_write = 0, busy, wr_valid = 0, wr_ready;
  logic rd_valid, rd_ready = 0, addr_valid, sink_valid, sink_ready = 0, src_valid = 0, src_ready;
  logic [31:0] start_addr = '0, wr_data = '0, rd_data, addr, sink_data, src_data = '0;
  logic [7:0] start_len = '0;
  logic [31:0] aq[$], wq[$], rq[$];
  int n_errors = 0, n_compared = 0, seed = 32'h66c4_0324;
  pdph_if bus_if ();
  pdph_master pdph_master_inst (.ref_clk(ref_clk), .rst(rst), .start(start), .start_write(start_write),
    .start_addr(start_addr), .start_len(start_len), .busy(busy), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .bus(bus_if.master));
  pdph_target pdph_target_inst (.ref_clk(ref_clk), .rst(rst), .addr(addr), .addr_valid(addr_valid),
    .sink_valid(sink_valid), .sink_ready(sink_ready), .sink_data(sink_data), .src_valid(src_valid),
    .src_ready(src_ready), .src_data(src_data), .bus(bus_if.target));
  pdph_checker pdph_checker_inst (.ref_clk(ref_clk), .rst(rst), .frame_n(bus_if.frame_n),
    .irdy_n(bus_if.irdy_n), .trdy_n(bus_if.trdy_n), .write(bus_if.write), .m_ad(bus_if.m_ad),
    .m_ad_oe(bus_if.m_ad_oe), .t_ad_oe(bus_if.t_ad_oe));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Stream feeders with random stalls; notes what each end accepted
  always @(posedge ref_clk) begin
    if (wr_valid && wr_ready) wq.push_back(wr_data);
    if (src_valid && src_ready) rq.push_back(src_data);
    if (!rst) begin
      if (!wr_valid || wr_ready) begin
        wr_valid <= 1'($random(seed));
        wr_data <= 32'($random(seed));
      end
      if (!src_valid || src_ready) begin
        src_valid <= 1'($random(seed));
        src_data <= 32'($random(seed));
      end
      sink_ready <= 1'($random(seed));
      rd_ready <= 1'($random(seed));
    end
  end
  always @(posedge ref_clk) begin
    if (sink_valid && sink_ready) check("sink_data", sink_data, wq.pop_front());
    if (rd_valid && rd_ready) check("rd_data", rd_data, rq.pop_front());
    if (addr_valid) check("addr", addr, aq.pop_front());
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    for (int i = 0; i < 24; i++) begin
      @(posedge ref_clk);
      while (busy) @(posedge ref_clk);
      start <= 1;
      start_write <= 1'($random(seed));
      start_len <= 8'(i % 4 + 1);
      start_addr <= 32'($random(seed));
      @(posedge ref_clk);
      aq.push_back(start_addr);
      // Held start while busy must be ignored
      start_addr <= ~start_addr;
      @(posedge ref_clk);
      start <= 0;
    end
    while (busy) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
    summarize();
  end
  initial begin
    #500000;
    n_errors++;
    summarize();
  end
endmodule // tb
`default_nettype wire
